//--- rtl/swrc_params.svh
// Purpose: constants for the sleep, wake and reset-cause block
// Assumes: axi4-lite slave, 32-bit data, 125 MHz aclk
// Notes:   offsets are byte addresses
// Functional notes
// RL1: watchdog wake from sleep clears all four
// RL2: watchdog reset awake keeps powerdown, clears others
// RL3: reset pin wake sets timeout, clears rest
// RL4: powerdown set at power-up, cleared by sleep
// RL5: reset pin awake clears wakes, keeps others
// RL6: pin wake sets pin and timeout flags
// RL7: comparator wake sets comparator and timeout flags
// RL8: flags hold until reset; pin pulse alone ignored
// RL9: sleep entered only by sleep instruction
// RL10: sleep entry clears watchdog, sets flags, stops oscillator
// RL11: pins hold their state during sleep
// RL12: watchdog reset never drives reset pin low
// RL13: four enabled events wake through device reset
// RL14: pin change compares with last port capture
// RL15: stale mismatch wakes at once on sleep
// RL16: watchdog cleared on every wake
// RL17: power-up sets timeout, clears both wake flags
`ifndef SWRC_PARAMS_SVH
`define SWRC_PARAMS_SVH
`define SWRC_ADDR_STATUS   8'h00
`define SWRC_ADDR_CONFIG   8'h04
`define SWRC_ADDR_IRQ_STAT 8'h08
`define SWRC_ADDR_IRQ_EN   8'h0C
`define SWRC_ADDR_IRQ_CLR  8'h10
`define SWRC_ADDR_WDT      8'h14
`define SWRC_BIT_CMP_WAKE  7
`define SWRC_BIT_PIN_WAKE  6
`define SWRC_BIT_TIMEOUT   4
`define SWRC_BIT_POWERDOWN 3
`define SWRC_CFG_RESET     8'h0F
`define SWRC_WDT_PERIOD_US 18000
`define SWRC_CLK_MHZ       125
`define SWRC_WDT_CYCLES    (`SWRC_WDT_PERIOD_US * `SWRC_CLK_MHZ)
`define SWRC_RESP_OKAY     2'b00
`define SWRC_RESP_SLVERR   2'b10
`endif

//--- rtl/swrc_pkg.sv
// Purpose: types for the sleep, wake and reset-cause block
// Assumes: nothing
// Notes:   cause codes drive the flag update table
package swrc_pkg;
   typedef enum logic [1:0] {
      SWRC_RUN   = 2'b00,
      SWRC_SLEEP = 2'b01,
      SWRC_RESET = 2'b10
   } swrc_state_t;
   typedef enum logic [2:0] {
      SWRC_C_NONE   = 3'b000,
      SWRC_C_WDT    = 3'b001,
      SWRC_C_PIN    = 3'b010,
      SWRC_C_CHANGE = 3'b011,
      SWRC_C_CMP    = 3'b100
   } swrc_cause_t;
endpackage

//--- rtl/swrc_sleep_wake.sv
// Purpose: sleep control, wake sources and reset-cause flags
// Assumes: core issues sleep_instr and port_access as one-cycle pulses
// Notes:   flags hold across a device reset; aresetn initialises them, reset events and sleep entry update them
`timescale 1ns/10ps
`include "swrc_params.svh"
module swrc_sleep_wake #(
   parameter int unsigned WDT_CYCLES = `SWRC_WDT_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        sleep_instr,
   input  wire logic        clrwdt_instr,
   input  wire logic        port_access,
   input  wire logic        ext_reset_pin_n,
   input  wire logic        port_pin_zero,
   input  wire logic        port_pin_one,
   input  wire logic        port_pin_three,
   input  wire logic        cmp_out,
   input  wire logic [2:0]  pin_out_in,
   input  wire logic [2:0]  pin_oe_n_in,
   output logic [2:0]       pin_out,
   output logic [2:0]       pin_oe_n,
   output logic             ext_reset_pin_oe_n,
   output logic             device_reset,
   output logic             osc_enable,
   output logic             in_sleep,
   output logic             irq,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // pin synchronisers: first stage read only by second
   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_ff <= 5'h1F;
         sync2_ff <= 5'h1F;
      end else begin
         sync1_ff <= {ext_reset_pin_n, cmp_out, port_pin_three, port_pin_one, port_pin_zero};
         sync2_ff <= sync1_ff;
      end
   end
   wire [2:0] pins_s   = sync2_ff[2:0];
   wire       cmp_s    = sync2_ff[3];
   wire       rstpin_s = sync2_ff[4];

   swrc_pkg::swrc_state_t state_ff;
   swrc_pkg::swrc_state_t nxt_state;
   logic        timeout_flag_n;
   logic        powerdown_flag_n;
   logic        pin_wake_flag;
   logic        comparator_wake_flag;
   logic [2:0]  pin_latch_ff;
   logic        cmp_latch_ff;
   logic [31:0] watchdog_counter;
   logic [7:0]  cfg_ff;
   logic [3:0]  irq_stat_ff;
   logic [3:0]  irq_en_ff;
   logic [2:0]  hold_out_ff;
   logic [2:0]  hold_oe_n_ff;

   wire cfg_pin_rst = cfg_ff[0];
   wire cfg_wdt_en  = cfg_ff[1];
   wire cfg_gp_wake = cfg_ff[2];
   wire cfg_cmp_wk  = cfg_ff[3];
   wire asleep      = (state_ff == swrc_pkg::SWRC_SLEEP);
   wire wdt_expire  = cfg_wdt_en && (watchdog_counter >= WDT_CYCLES - 1);
   wire pin_evt     = cfg_pin_rst && !rstpin_s;
   wire gp_mismatch = cfg_gp_wake && (pins_s != pin_latch_ff); // RL14 RL15
   wire cmp_change  = cfg_cmp_wk && (cmp_s != cmp_latch_ff);
   // priority: reset pin, watchdog, pin change, comparator
   wire swrc_pkg::swrc_cause_t cause =
      (state_ff == swrc_pkg::SWRC_RESET) ? swrc_pkg::SWRC_C_NONE :
      pin_evt                             ? swrc_pkg::SWRC_C_PIN :
      wdt_expire                          ? swrc_pkg::SWRC_C_WDT :
      (asleep && gp_mismatch)             ? swrc_pkg::SWRC_C_CHANGE : // RL13
      (asleep && cmp_change)              ? swrc_pkg::SWRC_C_CMP :
                                            swrc_pkg::SWRC_C_NONE;
   wire reset_evt = (cause != swrc_pkg::SWRC_C_NONE);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         swrc_pkg::SWRC_RUN: begin
            if (reset_evt)
               nxt_state = swrc_pkg::SWRC_RESET;
            else if (sleep_instr)
               nxt_state = swrc_pkg::SWRC_SLEEP; // RL9
         end
         swrc_pkg::SWRC_SLEEP: begin
            if (reset_evt)
               nxt_state = swrc_pkg::SWRC_RESET; // RL13
         end
         // device reset held while the pin is still low
         swrc_pkg::SWRC_RESET: begin
            if (!(cfg_pin_rst && !rstpin_s))
               nxt_state = swrc_pkg::SWRC_RUN;
         end
         default: nxt_state = swrc_pkg::SWRC_RUN;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= swrc_pkg::SWRC_RUN;
         timeout_flag_n <= 1'b1; // RL17
         powerdown_flag_n <= 1'b1; // RL4
         pin_wake_flag <= 1'b0; // RL17
         comparator_wake_flag <= 1'b0; // RL17
      end else begin
         state_ff <= nxt_state;
         if (state_ff == swrc_pkg::SWRC_RUN && sleep_instr && !reset_evt) begin
            timeout_flag_n <= 1'b1; // RL10
            powerdown_flag_n <= 1'b0; // RL4 RL10
         end
         // flags change only on a taken reset event or sleep entry; pin low while in reset is ignored
         case (cause)
            swrc_pkg::SWRC_C_WDT: begin
               timeout_flag_n <= 1'b0; // RL1 RL2
               if (asleep)
                  powerdown_flag_n <= 1'b0; // RL1
               pin_wake_flag <= 1'b0;
               comparator_wake_flag <= 1'b0;
            end
            swrc_pkg::SWRC_C_PIN: begin
               if (asleep) begin
                  timeout_flag_n <= 1'b1; // RL3
                  powerdown_flag_n <= 1'b0;
               end
               pin_wake_flag <= 1'b0; // RL5
               comparator_wake_flag <= 1'b0;
            end
            swrc_pkg::SWRC_C_CHANGE: begin
               timeout_flag_n <= 1'b1; // RL6
               powerdown_flag_n <= 1'b0;
               pin_wake_flag <= 1'b1;
               comparator_wake_flag <= 1'b0;
            end
            swrc_pkg::SWRC_C_CMP: begin
               timeout_flag_n <= 1'b1; // RL7
               powerdown_flag_n <= 1'b0;
               pin_wake_flag <= 1'b0;
               comparator_wake_flag <= 1'b1;
            end
            default: ; // RL8
         endcase
      end
   end

   // port capture references for wake-on-change
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_latch_ff <= 3'h0;
         cmp_latch_ff <= 1'b0;
      end else begin
         if (port_access)
            pin_latch_ff <= pins_s; // RL14
         if (!asleep)
            cmp_latch_ff <= cmp_s;
      end
   end

   // watchdog: cleared by clrwdt, sleep entry, any wake or device reset
   wire wdt_clear = clrwdt_instr || (sleep_instr && !asleep) || reset_evt ||
                    (state_ff == swrc_pkg::SWRC_RESET);
   always_ff @(posedge aclk) begin
      if (!aresetn)
         watchdog_counter <= 32'h0000_0000;
      else if (wdt_clear || !cfg_wdt_en)
         watchdog_counter <= 32'h0000_0000; // RL10 RL16
      else
         watchdog_counter <= watchdog_counter + 32'h0000_0001; // RL10
   end

   // pin hold during sleep
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_out_ff <= 3'h0;
         hold_oe_n_ff <= 3'h7;
      end else if (!asleep) begin
         hold_out_ff <= pin_out_in;
         hold_oe_n_ff <= pin_oe_n_in;
      end
   end
   assign pin_out  = asleep ? hold_out_ff : pin_out_in; // RL11
   assign pin_oe_n = asleep ? hold_oe_n_ff : pin_oe_n_in; // RL11
   assign ext_reset_pin_oe_n = 1'b1; // RL12
   assign device_reset = (state_ff == swrc_pkg::SWRC_RESET); // RL13
   assign osc_enable = !asleep; // RL10
   assign in_sleep = asleep;

   // interrupt events: bit0 sleep entry, bit1 wake/reset, bit2 watchdog, bit3 pin reset
   wire [3:0] irq_evt = {cause == swrc_pkg::SWRC_C_PIN, cause == swrc_pkg::SWRC_C_WDT,
                         reset_evt, state_ff == swrc_pkg::SWRC_RUN && sleep_instr && !reset_evt};
   assign irq = |(irq_stat_ff & irq_en_ff);

   // axi4-lite slave
   logic       bvalid_ff;
   logic       rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] bresp_ff;
   logic [1:0] rresp_ff;
   wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
   wire rd_go = s_axi_arvalid && !rvalid_ff;
   wire wr_cfg = wr_go && s_axi_awaddr == `SWRC_ADDR_CONFIG && s_axi_wstrb[0];
   wire wr_en  = wr_go && s_axi_awaddr == `SWRC_ADDR_IRQ_EN && s_axi_wstrb[0];
   wire wr_clr = wr_go && s_axi_awaddr == `SWRC_ADDR_IRQ_CLR && s_axi_wstrb[0];
   wire wr_ok  = s_axi_awaddr == `SWRC_ADDR_CONFIG || s_axi_awaddr == `SWRC_ADDR_IRQ_EN ||
                 s_axi_awaddr == `SWRC_ADDR_IRQ_CLR;
   wire [31:0] status_word = {24'h00_0000, comparator_wake_flag, pin_wake_flag, 1'b0,
                              timeout_flag_n, powerdown_flag_n, 3'h0};
   wire rd_ok = s_axi_araddr == `SWRC_ADDR_STATUS || s_axi_araddr == `SWRC_ADDR_CONFIG ||
                s_axi_araddr == `SWRC_ADDR_IRQ_STAT || s_axi_araddr == `SWRC_ADDR_IRQ_EN ||
                s_axi_araddr == `SWRC_ADDR_IRQ_CLR || s_axi_araddr == `SWRC_ADDR_WDT;
   wire [31:0] rd_word =
      (s_axi_araddr == `SWRC_ADDR_STATUS)   ? status_word :
      (s_axi_araddr == `SWRC_ADDR_CONFIG)   ? {24'h00_0000, cfg_ff} :
      (s_axi_araddr == `SWRC_ADDR_IRQ_STAT) ? {28'h000_0000, irq_stat_ff} :
      (s_axi_araddr == `SWRC_ADDR_IRQ_EN)   ? {28'h000_0000, irq_en_ff} :
      (s_axi_araddr == `SWRC_ADDR_WDT)      ? watchdog_counter : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_ff <= `SWRC_CFG_RESET;
         irq_en_ff <= 4'h0;
         irq_stat_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         bresp_ff <= `SWRC_RESP_OKAY;
         rresp_ff <= `SWRC_RESP_OKAY;
      end else begin
         if (wr_cfg)
            cfg_ff <= s_axi_wdata[7:0];
         if (wr_en)
            irq_en_ff <= s_axi_wdata[3:0];
         // set wins over clear
         irq_stat_ff <= (irq_stat_ff & ~(wr_clr ? s_axi_wdata[3:0] : 4'h0)) | irq_evt;
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? `SWRC_RESP_OKAY : `SWRC_RESP_SLVERR;
         end else if (s_axi_bready)
            bvalid_ff <= 1'b0;
         if (rd_go) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_ok ? `SWRC_RESP_OKAY : `SWRC_RESP_SLVERR;
         end else if (s_axi_rready)
            rvalid_ff <= 1'b0;
      end
   end
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = rd_go;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   // assertions
   property p_wdt_sleep_wake;
      @(posedge aclk) disable iff (!aresetn)
      (cause == swrc_pkg::SWRC_C_WDT && asleep) |=> !timeout_flag_n && !powerdown_flag_n;
   endproperty
   a_wdt_sleep_wake: assert property (p_wdt_sleep_wake) else $error("wdt wake flags"); // RL1
   property p_wdt_awake;
      @(posedge aclk) disable iff (!aresetn)
      (cause == swrc_pkg::SWRC_C_WDT && !asleep) |=>
         !timeout_flag_n && powerdown_flag_n == $past(powerdown_flag_n);
   endproperty
   a_wdt_awake: assert property (p_wdt_awake) else $error("wdt awake flags"); // RL2
   property p_pin_wake;
      @(posedge aclk) disable iff (!aresetn)
      (cause == swrc_pkg::SWRC_C_CHANGE) |=> pin_wake_flag && timeout_flag_n && device_reset;
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("pin wake flags"); // RL6
   property p_cmp_wake;
      @(posedge aclk) disable iff (!aresetn)
      (cause == swrc_pkg::SWRC_C_CMP) |=> comparator_wake_flag && !pin_wake_flag;
   endproperty
   a_cmp_wake: assert property (p_cmp_wake) else $error("cmp wake flags"); // RL7
   sequence s_enter_sleep;
      !asleep ##1 asleep;
   endsequence
   property p_sleep_only_instr;
      @(posedge aclk) disable iff (!aresetn)
      s_enter_sleep |-> $past(sleep_instr);
   endproperty
   a_sleep_only_instr: assert property (p_sleep_only_instr) else $error("sleep w/o instr"); // RL9
   property p_sleep_entry;
      @(posedge aclk) disable iff (!aresetn)
      s_enter_sleep |-> !powerdown_flag_n && timeout_flag_n && !osc_enable
         && watchdog_counter == 32'h0000_0000;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry"); // RL10
   property p_no_pin_drive;
      @(posedge aclk) disable iff (!aresetn) ext_reset_pin_oe_n;
   endproperty
   a_no_pin_drive: assert property (p_no_pin_drive) else $error("reset pin driven"); // RL12
   property p_wake_clears_wdt;
      @(posedge aclk) disable iff (!aresetn)
      (asleep && reset_evt) |=> watchdog_counter == 32'h0000_0000 && device_reset;
   endproperty
   a_wake_clears_wdt: assert property (p_wake_clears_wdt) else $error("wdt not cleared"); // RL16
   property p_pin_rst_sleep;
      @(posedge aclk) disable iff (!aresetn)
      (cause == swrc_pkg::SWRC_C_PIN && asleep) |=>
         timeout_flag_n && !powerdown_flag_n && !pin_wake_flag && !comparator_wake_flag;
   endproperty
   a_pin_rst_sleep: assert property (p_pin_rst_sleep) else $error("pin reset wake flags"); // RL3
   property p_pin_rst_awake;
      @(posedge aclk) disable iff (!aresetn)
      (cause == swrc_pkg::SWRC_C_PIN && !asleep) |=> !pin_wake_flag && !comparator_wake_flag
         && $stable(timeout_flag_n) && $stable(powerdown_flag_n);
   endproperty
   a_pin_rst_awake: assert property (p_pin_rst_awake) else $error("pin reset awake flags"); // RL5
   // outside a reset event or sleep entry nothing may touch the cause flags
   property p_flags_hold;
      @(posedge aclk) disable iff (!aresetn)
      (!reset_evt && !(sleep_instr && state_ff == swrc_pkg::SWRC_RUN)) |=>
         $stable({timeout_flag_n, powerdown_flag_n, pin_wake_flag, comparator_wake_flag});
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("flags changed"); // RL8
   property p_pins_frozen;
      @(posedge aclk) disable iff (!aresetn)
      (asleep ##1 asleep) |-> $stable(pin_out) && $stable(pin_oe_n);
   endproperty
   a_pins_frozen: assert property (p_pins_frozen) else $error("pins moved in sleep"); // RL11
   property p_change_wake;
      @(posedge aclk) disable iff (!aresetn)
      (asleep && cfg_gp_wake && pins_s != pin_latch_ff && !pin_evt && !wdt_expire) |=>
         device_reset && pin_wake_flag;
   endproperty
   a_change_wake: assert property (p_change_wake) else $error("no wake on pin change"); // RL14
endmodule

//--- sim/tb_top.sv
// Purpose: self-checking bench for the sleep, wake and reset-cause block
// Assumes: watchdog shortened to 50 cycles; bus answers within a few cycles
// Notes:   bus waits end only by the watchdog process, wake waits are bounded
`timescale 1ns/10ps
`include "swrc_params.svh"
module tb_top;
   localparam int unsigned WDT = 50;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        sleep_instr = 1'b0, clrwdt_instr = 1'b0, port_access = 1'b0;
   logic        ext_reset_pin_n = 1'b1, cmp_out = 1'b0;
   logic        port_pin_zero = 1'b1, port_pin_one = 1'b1, port_pin_three = 1'b1;
   logic [2:0]  pin_out_in = 3'h5, pin_oe_n_in = 3'h2, pin_out, pin_oe_n;
   logic        ext_reset_pin_oe_n, device_reset, osc_enable, in_sleep, irq;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   int          err_total = 0;
   int          checks = 0;

   always #4 aclk = ~aclk;

   swrc_sleep_wake #(
      .WDT_CYCLES(WDT)
   ) swrc_sleep_wake_inst (
      .aclk               (aclk),
      .aresetn            (aresetn),
      .sleep_instr        (sleep_instr),
      .clrwdt_instr       (clrwdt_instr),
      .port_access        (port_access),
      .ext_reset_pin_n    (ext_reset_pin_n),
      .port_pin_zero      (port_pin_zero),
      .port_pin_one       (port_pin_one),
      .port_pin_three     (port_pin_three),
      .cmp_out            (cmp_out),
      .pin_out_in         (pin_out_in),
      .pin_oe_n_in        (pin_oe_n_in),
      .pin_out            (pin_out),
      .pin_oe_n           (pin_oe_n),
      .ext_reset_pin_oe_n (ext_reset_pin_oe_n),
      .device_reset       (device_reset),
      .osc_enable         (osc_enable),
      .in_sleep           (in_sleep),
      .irq                (irq),
      .s_axi_awaddr       (s_axi_awaddr),
      .s_axi_awvalid      (s_axi_awvalid),
      .s_axi_awready      (s_axi_awready),
      .s_axi_wdata        (s_axi_wdata),
      .s_axi_wstrb        (s_axi_wstrb),
      .s_axi_wvalid       (s_axi_wvalid),
      .s_axi_wready       (s_axi_wready),
      .s_axi_bresp        (s_axi_bresp),
      .s_axi_bvalid       (s_axi_bvalid),
      .s_axi_bready       (s_axi_bready),
      .s_axi_araddr       (s_axi_araddr),
      .s_axi_arvalid      (s_axi_arvalid),
      .s_axi_arready      (s_axi_arready),
      .s_axi_rdata        (s_axi_rdata),
      .s_axi_rresp        (s_axi_rresp),
      .s_axi_rvalid       (s_axi_rvalid),
      .s_axi_rready       (s_axi_rready)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // responses are captured at the negedge, before the slave may move on
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
      @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(negedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask

   task automatic st(input logic [31:0] exp);
      axi_rd(`SWRC_ADDR_STATUS, rd, rs);
      chk(rd, exp);
   endtask

   // one-cycle core pulse: 0 sleep, 1 port access, 2 watchdog clear
   task automatic pulse(input int which);
      @(posedge aclk);
      case (which)
         0: sleep_instr <= 1'b1;
         1: port_access <= 1'b1;
         default: clrwdt_instr <= 1'b1;
      endcase
      @(posedge aclk);
      sleep_instr <= 1'b0;
      port_access <= 1'b0;
      clrwdt_instr <= 1'b0;
   endtask

   task automatic pin_rst;
      @(posedge aclk);
      ext_reset_pin_n <= 1'b0;
      repeat (3) @(posedge aclk);
      ext_reset_pin_n <= 1'b1;
   endtask

   // bounded wait for leaving sleep, then let the device reset settle
   task automatic wake(input int bound);
      int n;
      n = 0;
      // callers return in the edge's time step, before the state has moved
      @(negedge aclk);
      while (in_sleep !== 1'b0 && n < bound) begin
         @(negedge aclk);
         n++;
      end
      chk({31'h0000_0000, in_sleep}, 32'h0000_0000);
      repeat (6) @(posedge aclk);
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      give_verdict;
   end

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk({30'h0000_0000, in_sleep, osc_enable}, 32'h0000_0001);
      st(32'h0000_0018);
      axi_rd(`SWRC_ADDR_CONFIG, rd, rs);
      chk(rd, 32'h0000_000F);
      axi_rd(8'h3C, rd, rs);
      chk({rd[29:0], rs}, {30'h0000_0000, `SWRC_RESP_SLVERR});
      axi_wr(`SWRC_ADDR_STATUS, 32'h0000_0000, rs);
      chk({30'h0000_0000, rs}, {30'h0000_0000, `SWRC_RESP_SLVERR});
      axi_wr(`SWRC_ADDR_IRQ_EN, 32'h0000_0001, rs);
      $display("test reset done");
      for (int i = 0; i < 3 * WDT && device_reset !== 1'b1; i++) begin
         @(negedge aclk);
         chk({31'h0000_0000, ext_reset_pin_oe_n}, 32'h0000_0001);
      end
      chk({31'h0000_0000, device_reset}, 32'h0000_0001);
      repeat (4) @(posedge aclk);
      st(32'h0000_0008);
      axi_wr(`SWRC_ADDR_CONFIG, 32'h0000_000D, rs);
      pin_rst;
      repeat (8) @(posedge aclk);
      st(32'h0000_0008);
      $display("test awake resets done");
      pulse(1);
      pulse(0);
      @(negedge aclk);
      chk({30'h0000_0000, in_sleep, osc_enable}, 32'h0000_0002);
      @(posedge aclk);
      pin_out_in <= 3'h2;
      pin_oe_n_in <= 3'h5;
      repeat (2) @(negedge aclk);
      chk({26'h000_0000, pin_oe_n, pin_out}, {26'h000_0000, 3'h2, 3'h5});
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      pin_rst;
      wake(20);
      st(32'h0000_0010);
      chk({26'h000_0000, pin_oe_n, pin_out}, {26'h000_0000, 3'h5, 3'h2});
      axi_wr(`SWRC_ADDR_IRQ_CLR, 32'h0000_0001, rs);
      @(negedge aclk);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      axi_rd(`SWRC_ADDR_IRQ_STAT, rd, rs);
      chk(rd, 32'h0000_000E);
      $display("test pin reset wake done");
      pulse(1);
      pulse(0);
      @(posedge aclk);
      port_pin_zero <= 1'b0;
      wake(20);
      st(32'h0000_0050);
      pulse(0);
      wake(8);
      st(32'h0000_0050);
      $display("test pin change wake done");
      pulse(1);
      pulse(0);
      @(posedge aclk);
      cmp_out <= 1'b1;
      wake(20);
      st(32'h0000_0090);
      $display("test comparator wake done");
      axi_wr(`SWRC_ADDR_CONFIG, 32'h0000_000F, rs);
      pulse(2);
      pulse(1);
      pulse(0);
      wake(3 * WDT);
      st(32'h0000_0000);
      axi_rd(`SWRC_ADDR_WDT, rd, rs);
      chk({31'h0000_0000, rd > 32'h0000_0019}, 32'h0000_0000);
      $display("test watchdog wake done");
      give_verdict;
   end
endmodule
